/* test/vpd_dut_pins.sv */
`timescale 1ns/1ps
module vpd_dut_pins #(parameter NPINS = 8) (
   input  logic [NPINS-1:0]   i_drv_en,
   input  logic [NPINS-1:0]   i_drv_val,
   input  logic [2*NPINS-1:0] i_lvl,
   output logic [NPINS-1:0]   o_hi,
   output logic [NPINS-1:0]   o_lo
);
   // released pin settles to its load: 0 low, 1 high, 2 midband, never the last driven value
   always_comb begin
      for (int p = 0; p < NPINS; p++) begin
         o_hi[p] = i_drv_en[p] ? i_drv_val[p] : (i_lvl[2*p+:2] == 2'h1);
         o_lo[p] = i_drv_en[p] ? !i_drv_val[p] : (i_lvl[2*p+:2] == 2'h0);
      end
   end
endmodule // vpd_dut_pins

/* test/vpd_pin_decoder_bench.sv */
`timescale 1ns/1ps
`include "vpd_map.vh"
module vpd_pin_decoder_bench;
   logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, vv = 0, vf = 0, bend = 0, err;
   logic [7:0]  paddr = 0, items = 1, gval = 0, src = 0;
   logic [31:0] pwdata = 0, rdata, codes = 32'h4444_4444;
   logic [1:0]  gmode = 0;
   logic [15:0] lvl = 16'h0000;
   wire  [31:0] prdata;
   wire         pready, pslverr, src_take, cap_v, fail, rej, irq;
   wire  [1:0]  tmode;
   wire  [7:0]  drv_en, drv_val, term, cap_d, cap_m, fpins, hi, lo;
   int          num_errors = 0, check_count = 0;
   always #2.5 clk = ~clk;
   vpd_pin_decoder #(.NPINS(8)) dut_u (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_vec_valid(vv), .i_vec_first(vf), .i_burst_end(bend), .i_vec_items(items),
      .i_vec_codes(codes), .i_vec_grp_mode(gmode), .i_vec_grp_val(gval), .i_src_data(src), .i_pin_hi(hi),
      .i_pin_lo(lo), .o_drv_en(drv_en), .o_drv_val(drv_val), .o_term_act(term), .o_term_mode(tmode),
      .o_src_take(src_take), .o_cap_valid(cap_v), .o_cap_data(cap_d), .o_cap_mask(cap_m), .o_fail(fail),
      .o_fail_pins(fpins), .o_vec_reject(rej), .o_irq(irq));
   vpd_dut_pins #(.NPINS(8)) pins_u (.i_drv_en(drv_en), .i_drv_val(drv_val), .i_lvl(lvl), .o_hi(hi), .o_lo(lo));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      #1;
   endtask
   task automatic vec(input logic [31:0] c, input logic [7:0] n, input logic [1:0] m, input logic [7:0] g,
                      input logic f);
      @(posedge clk);
      vv <= 1'b1;
      vf <= f;
      codes <= c;
      items <= n;
      gmode <= m;
      gval <= g;
      @(posedge clk);
      vv <= 1'b0;
      vf <= 1'b0;
      // pulses launched at the taking edge stand only until the next edge
      #1;
   endtask
   task automatic wait_fail;
      // bounded, the check pipeline is a few cycles deep
      for (int n = 0; n < 12 && fail !== 1'b1; n++) @(posedge clk) #1;
   endtask
   task automatic t_reset;
      chk({tmode, drv_en, term}, 18'h0_00FF);
      apb(1'b0, `VPD_REG_CFG, 32'h0);
      chk(rdata, 32'h0);
      apb(1'b0, `VPD_REG_ITEMS, 32'h0);
      chk(rdata, 32'h1);
      apb(1'b0, `VPD_REG_GRPW, 32'h0);
      chk(rdata, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      chk(rdata, 32'h0);
   endtask
   task automatic t_drive;
      vec(32'hF654_3210, 8'h01, `VPD_GRP_SYM, 8'h00, 1'b1);
      chk({drv_val & 8'h03, drv_en, term}, 24'h02_03FC);
      vec(32'h9999_9999, 8'h01, `VPD_GRP_SYM, 8'h00, 1'b0);
      chk({drv_val & 8'h03, drv_en}, 16'h0203);
   endtask
   task automatic t_static;
      apb(1'b1, `VPD_REG_STATIC, 32'h0000_00A5);
      repeat (2) @(posedge clk);
      #1;
      chk({drv_val, drv_en}, 16'hA5FF);
      @(posedge clk);
      bend <= 1'b1;
      @(posedge clk);
      bend <= 1'b0;
      repeat (4) @(posedge clk);
      apb(1'b0, `VPD_REG_PINSTATE, 32'h0);
      chk(rdata, 32'h0000_A5FF);
      apb(1'b0, `VPD_REG_STATUS, 32'h0);
      chk(rdata[`VPD_ST_DONE], 1'b1);
   endtask
   task automatic t_group;
      apb(1'b1, `VPD_REG_GRPW, 32'h4);
      vec(32'h4444_4444, 8'h01, `VPD_GRP_DRV, 8'h05, 1'b0);
      chk({rej, drv_val & 8'h0F, drv_en}, 17'h0_050F);
      vec(32'h4444_4444, 8'h01, `VPD_GRP_DRV, 8'h15, 1'b0);
      chk({rej, drv_en}, 9'h10F);
      vec(32'h4444_4444, 8'h02, `VPD_GRP_SYM, 8'h00, 1'b0);
      chk({rej, drv_en}, 9'h10F);
      vec(32'h4444_4444, 8'h01, `VPD_GRP_CMP, 8'h05, 1'b0);
      chk({rej, drv_en}, 9'h000);
      apb(1'b1, `VPD_REG_GRPW, 32'h1);
      vec(32'h4444_4444, 8'h01, `VPD_GRP_DRV, 8'h01, 1'b0);
      chk(rej, 1'b1);
      apb(1'b0, `VPD_REG_STATUS, 32'h0);
      chk(rdata[`VPD_ST_REJECT], 1'b1);
   endtask
   task automatic t_compare;
      lvl = 16'h4660;
      apb(1'b1, `VPD_REG_CFG, 32'h4);
      // release all pins first so no stale driven level reaches the comparators
      vec(32'h4444_4444, 8'h01, `VPD_GRP_SYM, 8'h00, 1'b0);
      repeat (8) @(posedge clk);
      apb(1'b1, `VPD_REG_IRQ_CLR, 32'hF);
      apb(1'b1, `VPD_REG_IRQ_EN, 32'h0);
      vec(32'h2466_5532, 8'h01, `VPD_GRP_SYM, 8'h00, 1'b1);
      wait_fail;
      chk({fail, fpins}, 9'h19A);
      chk({cap_v, cap_m, cap_d & 8'h30}, 17'h1_3020);
      apb(1'b0, `VPD_REG_STATUS, 32'h0);
      chk({irq, rdata[3:0] & 4'h9}, 5'h09);
      apb(1'b1, `VPD_REG_IRQ_EN, 32'h1);
      chk(irq, 1'b1);
      apb(1'b1, `VPD_REG_IRQ_CLR, 32'h1);
      chk(irq, 1'b0);
   endtask
   task automatic t_source;
      apb(1'b1, `VPD_REG_CFG, 32'hA);
      @(posedge clk);
      src <= 8'h03;
      vec(32'h4444_4487, 8'h01, `VPD_GRP_SYM, 8'h00, 1'b1);
      chk({src_take, tmode, drv_val[0], drv_en}, 12'hD01);
      wait_fail;
      chk({fail, fpins}, 9'h102);
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      end_of_test;
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      #1;
      t_reset;
      t_drive;
      t_static;
      t_group;
      t_compare;
      t_source;
      end_of_test;
   end
endmodule // vpd_pin_decoder_bench

/* test/vpd_pin_decoder_properties.sv */
`timescale 1ns/1ps
`include "vpd_map.vh"
module vpd_pin_decoder_props #(parameter NPINS = 8) (
   input wire               i_ref_clk,
   input wire               i_rst,
   input wire               i_psel,
   input wire               i_penable,
   input wire               i_pwrite,
   input wire [7:0]         i_paddr,
   input wire [31:0]        i_pwdata,
   input wire               i_vec_valid,
   input wire               i_burst_end,
   input wire [7:0]         i_vec_items,
   input wire [NPINS*4-1:0] i_vec_codes,
   input wire [1:0]         i_vec_grp_mode,
   input wire [NPINS-1:0]   i_vec_grp_val,
   input wire [NPINS-1:0]   i_src_data,
   input wire [NPINS-1:0]   o_drv_en,
   input wire [NPINS-1:0]   o_drv_val,
   input wire [NPINS-1:0]   o_term_act,
   input wire               o_src_take,
   input wire               o_fail,
   input wire               o_vec_reject
);
   function automatic [NPINS-1:0] sel(input [NPINS*4-1:0] c, input [3:0] k);
      for (int p = 0; p < NPINS; p++) sel[p] = (c[4*p+:4] == k);
   endfunction
   reg  [7:0]         items_r;
   reg  [5:0]         grpw_r;
   reg                src_on_r;
   reg                seen_r;
   reg  [NPINS*4-1:0] codes_q;
   reg  [NPINS-1:0]   src_q;
   reg  [NPINS-1:0]   val_q;
   wire               wr = i_psel && i_penable && i_pwrite;
   wire [NPINS-1:0]   grp_m = ~({NPINS{1'b1}} << grpw_r);
   wire               grp_ok = grpw_r >= 2 && grpw_r <= NPINS && (i_vec_grp_val & ~grp_m) == 0;
   wire               item_ok = i_vec_valid && i_vec_items == items_r;
   wire [NPINS-1:0]   q0 = sel(codes_q, `VPD_SYM_D0);
   wire [NPINS-1:0]   q1 = sel(codes_q, `VPD_SYM_D1);
   wire [NPINS-1:0]   q7 = sel(codes_q, `VPD_SYM_SRC_D);
   wire [NPINS-1:0]   qn = sel(codes_q, 4'h2) | sel(codes_q, 4'h3) | sel(codes_q, 4'h4) | sel(codes_q, 4'h5)
                           | sel(codes_q, 4'h6);
   // shadow copies of the registers, so the checker needs no internal signals
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         items_r <= `VPD_RST_ITEMS;
         grpw_r <= `VPD_RST_GRPW;
         src_on_r <= 1'b0;
         seen_r <= 1'b0;
      end else begin
         if (wr && i_paddr == `VPD_REG_ITEMS) items_r <= i_pwdata[7:0];
         if (wr && i_paddr == `VPD_REG_GRPW) grpw_r <= i_pwdata[5:0];
         if (wr && i_paddr == `VPD_REG_CFG) src_on_r <= i_pwdata[`VPD_CFG_SRC_BIT];
         if (i_vec_valid || (wr && i_paddr == `VPD_REG_STATIC)) seen_r <= 1'b1;
      end
   end
   always @(posedge i_ref_clk) begin
      codes_q <= i_vec_codes;
      src_q <= i_src_data;
      val_q <= i_vec_grp_val;
   end
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   sequence s_sym; item_ok && i_vec_grp_mode == `VPD_GRP_SYM; endsequence
   sequence s_bad; i_vec_valid && i_vec_items != items_r; endsequence
   sequence s_still; $stable(o_drv_en) && $stable(o_drv_val); endsequence
   property p_reset; !seen_r |-> o_drv_en == 0; endproperty
   a_reset: assert property (p_reset) else $error("driver on before any vector");
   property p_term; o_term_act == ~o_drv_en; endproperty
   a_term: assert property (p_term) else $error("termination not on undriven pins");
   property p_drive; s_sym |=> ((o_drv_en & (q0 | q1)) == (q0 | q1)) && ((o_drv_val & (q0 | q1)) == q1); endproperty
   a_drive: assert property (p_drive) else $error("drive symbol wrong");
   property p_nodrv; s_sym |=> (o_drv_en & qn) == 0; endproperty
   a_nodrv: assert property (p_nodrv) else $error("compare symbol drives pin");
   property p_src; s_sym ##0 (src_on_r && |sel(i_vec_codes, `VPD_SYM_SRC_D)) |=> o_src_take && ((o_drv_val ^ src_q) & q7) == 0; endproperty
   a_src: assert property (p_src) else $error("source drive wrong");
   property p_reject; s_bad |=> o_vec_reject ##0 s_still; endproperty
   a_reject: assert property (p_reject) else $error("bad item count not rejected");
   property p_group; item_ok && i_vec_grp_mode == `VPD_GRP_DRV && grp_ok
      |=> ((o_drv_en & grp_m) == grp_m) && (((o_drv_val ^ val_q) & grp_m) == 0); endproperty
   a_group: assert property (p_group) else $error("group drive wrong");
   property p_grp_bad; item_ok && i_vec_grp_mode != `VPD_GRP_SYM && !grp_ok |=> o_vec_reject; endproperty
   a_grp_bad: assert property (p_grp_bad) else $error("bad group value taken");
   property p_hold; i_burst_end |=> s_still [*3]; endproperty
   a_hold: assert property (p_hold) else $error("pins moved after burst end");
   property p_fail; o_fail |-> $past(i_vec_valid, 4); endproperty
   a_fail: assert property (p_fail) else $error("fail pulse at wrong time");
endmodule // vpd_pin_decoder_props
bind vpd_pin_decoder vpd_pin_decoder_props #(.NPINS(NPINS)) u_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .i_vec_valid(i_vec_valid), .i_burst_end(i_burst_end), .i_vec_items(i_vec_items), .i_vec_codes(i_vec_codes),
   .i_vec_grp_mode(i_vec_grp_mode), .i_vec_grp_val(i_vec_grp_val), .i_src_data(i_src_data),
   .o_drv_en(o_drv_en), .o_drv_val(o_drv_val), .o_term_act(o_term_act), .o_src_take(o_src_take),
   .o_fail(o_fail), .o_vec_reject(o_vec_reject));

/* verilog/vpd_map.vh */
`ifndef VPD_MAP_VH
`define VPD_MAP_VH

// apb register byte offsets
`define VPD_REG_CFG       8'h00
`define VPD_REG_ITEMS     8'h04
`define VPD_REG_GRPW      8'h08
`define VPD_REG_STATIC    8'h0C
`define VPD_REG_STATUS    8'h10
`define VPD_REG_IRQ_EN    8'h14
`define VPD_REG_IRQ_CLR   8'h18
`define VPD_REG_FAILPINS  8'h1C
`define VPD_REG_PINSTATE  8'h20

// cfg fields
`define VPD_CFG_TERM_LSB  0
`define VPD_CFG_TERM_MSB  1
`define VPD_CFG_CAP_BIT   2
`define VPD_CFG_SRC_BIT   3

// termination modes
`define VPD_TERM_HIZ      2'h0
`define VPD_TERM_LOAD     2'h1
`define VPD_TERM_VTERM    2'h2

// status / irq bit positions
`define VPD_ST_FAIL       0
`define VPD_ST_REJECT     1
`define VPD_ST_DONE       2
`define VPD_ST_CAPT       3
`define VPD_ST_W          4

// reset values
`define VPD_RST_CFG       4'h0
`define VPD_RST_ITEMS     8'h01
`define VPD_RST_GRPW      6'h00

// group value modes
`define VPD_GRP_SYM       2'h0
`define VPD_GRP_DRV       2'h1
`define VPD_GRP_CMP       2'h2

// four bit pin symbol codes
`define VPD_SYM_D0        4'h0
`define VPD_SYM_D1        4'h1
`define VPD_SYM_L         4'h2
`define VPD_SYM_H         4'h3
`define VPD_SYM_X         4'h4
`define VPD_SYM_M         4'h5
`define VPD_SYM_V         4'h6
`define VPD_SYM_SRC_D     4'h7
`define VPD_SYM_SRC_E     4'h8
`define VPD_SYM_REPEAT    4'h9

`endif

/* verilog/vpd_pin_decoder.v */
`timescale 1ns/1ps
`include "vpd_map.vh"

module vpd_pin_decoder #(
   parameter NPINS = 8
) (
   input  wire               i_ref_clk,
   input  wire               i_rst,
   input  wire               i_psel,
   input  wire               i_penable,
   input  wire               i_pwrite,
   input  wire [7:0]         i_paddr,
   input  wire [31:0]        i_pwdata,
   output reg  [31:0]        o_prdata,
   output wire               o_pready,
   output reg                o_pslverr,
   input  wire               i_vec_valid,
   input  wire               i_vec_first,
   input  wire               i_burst_end,
   input  wire [7:0]         i_vec_items,
   input  wire [NPINS*4-1:0] i_vec_codes,
   input  wire [1:0]         i_vec_grp_mode,
   input  wire [NPINS-1:0]   i_vec_grp_val,
   input  wire [NPINS-1:0]   i_src_data,
   input  wire [NPINS-1:0]   i_pin_hi,
   input  wire [NPINS-1:0]   i_pin_lo,
   output reg  [NPINS-1:0]   o_drv_en,
   output reg  [NPINS-1:0]   o_drv_val,
   output reg  [NPINS-1:0]   o_term_act,
   output reg  [1:0]         o_term_mode,
   output reg                o_src_take,
   output reg                o_cap_valid,
   output reg  [NPINS-1:0]   o_cap_data,
   output reg  [NPINS-1:0]   o_cap_mask,
   output reg                o_fail,
   output reg  [NPINS-1:0]   o_fail_pins,
   output reg                o_vec_reject,
   output wire               o_irq
);

   reg  [3:0]         cfg_r;
   reg  [7:0]         items_r;
   reg  [5:0]         grpw_r;
   reg  [NPINS-1:0]   static_r;
   reg  [`VPD_ST_W-1:0] status_r;
   reg  [`VPD_ST_W-1:0] irq_en_r;
   reg  [NPINS*4-1:0] code_r;
   reg  [NPINS*4-1:0] ctx_r;
   reg  [NPINS*4-1:0] ctx_d1_r;
   reg  [NPINS*4-1:0] ctx_d2_r;
   reg  [1:0]         chk_r;
   reg                chk2_r;
   reg                static_ld_r;
   reg  [NPINS-1:0]   hi_s1_r;
   reg  [NPINS-1:0]   hi_s2_r;
   reg  [NPINS-1:0]   lo_s1_r;
   reg  [NPINS-1:0]   lo_s2_r;

   wire [NPINS*4-1:0] code_nxt;
   wire [NPINS-1:0]   grp_mask;
   wire [NPINS-1:0]   dec_drv_en;
   wire [NPINS-1:0]   dec_drv_val;
   wire [NPINS-1:0]   dec_src_use;
   wire [NPINS*4-1:0] dec_ctx;
   wire [NPINS-1:0]   fail_now;
   wire [NPINS-1:0]   cap_now;
   wire [`VPD_ST_W-1:0] status_set;
   wire [`VPD_ST_W-1:0] status_clr;
   wire               wr_en;
   wire               rd_setup;
   wire               grp_bad;
   wire               vec_bad;
   wire               apply;
   wire               src_on;
   wire               cap_on;
   wire               grp_narrow;
   wire               grp_wide;
   wire               grp_over;
   wire [NPINS-1:0]   fail_keep;

   assign src_on   = cfg_r[`VPD_CFG_SRC_BIT];
   assign cap_on   = cfg_r[`VPD_CFG_CAP_BIT];
   // no wait states: every register answers in its first access cycle
   assign o_pready = 1'b1;
   assign wr_en    = i_psel & i_penable & i_pwrite;
   assign rd_setup = i_psel & ~i_penable & ~i_pwrite;

   // a value in symbolic mode is ignored; otherwise it must fit the group
   assign grp_narrow = (grpw_r < 6'd2);
   assign grp_wide   = ({26'd0, grpw_r} > NPINS);
   assign grp_over   = |(i_vec_grp_val & ~grp_mask);
   assign grp_bad    = (i_vec_grp_mode != `VPD_GRP_SYM) & (grp_narrow | grp_wide | grp_over);
   assign vec_bad = (i_vec_items != items_r) | grp_bad;
   assign apply   = i_vec_valid & ~vec_bad;

   genvar p;
   generate
      for (p = 0; p < NPINS; p = p + 1) begin : g_pin
         wire [3:0] sym_in;
         wire [3:0] sym_res;
         wire       c_en;
         wire       c_exp;
         wire       c_mid;
         wire       c_vld;
         wire       hi;
         wire       lo;
         wire       drv_pick;
         wire       cmp_pick;

         assign grp_mask[p] = (p < grpw_r);
         assign drv_pick    = (i_vec_grp_mode == `VPD_GRP_DRV) & grp_mask[p];
         assign cmp_pick    = (i_vec_grp_mode == `VPD_GRP_CMP) & grp_mask[p];
         assign sym_in = drv_pick ?
                            (i_vec_grp_val[p] ? `VPD_SYM_D1 : `VPD_SYM_D0) :
                         cmp_pick ?
                            (i_vec_grp_val[p] ? `VPD_SYM_H : `VPD_SYM_L) :
                         i_vec_codes[p*4 +: 4];
         // repeat resolves to the held code, so it also chains across bursts
         assign sym_res = (sym_in == `VPD_SYM_REPEAT) ? code_r[p*4 +: 4] : sym_in;
         assign code_nxt[p*4 +: 4] = sym_res;

         vpd_sym_decode u_dec (
            .i_code    (sym_res),
            .i_src_bit (i_src_data[p]),
            .i_src_on  (src_on),
            .o_drv_en  (dec_drv_en[p]),
            .o_drv_val (dec_drv_val[p]),
            .o_cmp_en  (dec_ctx[p*4+3]),
            .o_exp_val (dec_ctx[p*4+2]),
            .o_mid_chk (dec_ctx[p*4+1]),
            .o_vld_chk (dec_ctx[p*4]),
            .o_src_use (dec_src_use[p])
         );

         assign c_en  = ctx_d2_r[p*4+3];
         assign c_exp = ctx_d2_r[p*4+2];
         assign c_mid = ctx_d2_r[p*4+1];
         assign c_vld = ctx_d2_r[p*4];
         assign hi    = hi_s2_r[p];
         assign lo    = lo_s2_r[p];
         assign fail_now[p] = chk2_r & ((c_en & (c_exp ? ~hi : ~lo)) |
                                        (c_mid & (hi | lo)) |
                                        (c_vld & ~(hi | lo)));
         assign cap_now[p]  = chk2_r & c_vld & cap_on;
      end
   endgenerate

   // comparator inputs come from the pin electronics, outside this clock
   // only the second stage is read; the first may still be settling
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         hi_s1_r <= {NPINS{1'b0}};
         hi_s2_r <= {NPINS{1'b0}};
         lo_s1_r <= {NPINS{1'b0}};
         lo_s2_r <= {NPINS{1'b0}};
      end else begin
         hi_s1_r <= i_pin_hi;
         hi_s2_r <= hi_s1_r;
         lo_s1_r <= i_pin_lo;
         lo_s2_r <= lo_s1_r;
      end
   end

   // pin state: vector apply, software static write, else hold
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         // held codes start as mask, so a repeat before any vector or static write stays idle
         code_r      <= {NPINS{`VPD_SYM_X}};
         ctx_r       <= {NPINS*4{1'b0}};
         o_drv_en    <= {NPINS{1'b0}};
         o_drv_val   <= {NPINS{1'b0}};
         o_term_act  <= {NPINS{1'b1}};
         o_src_take  <= 1'b0;
         chk_r       <= 2'b00;
      end else begin
         o_src_take <= apply & (|dec_src_use);
         chk_r      <= {chk_r[0], apply};
         if (apply) begin
            code_r     <= code_nxt;
            ctx_r      <= dec_ctx;
            o_drv_en   <= dec_drv_en;
            o_drv_val  <= dec_drv_val;
            o_term_act <= ~dec_drv_en;
         end else if (static_ld_r) begin
            // a vector applied in the same cycle wins over a pending static write
            code_r     <= {NPINS*4{1'b0}} | static_codes(static_r);
            ctx_r      <= {NPINS*4{1'b0}};
            o_drv_en   <= {NPINS{1'b1}};
            o_drv_val  <= static_r;
            o_term_act <= {NPINS{1'b0}};
         end
         // burst end changes nothing: the last vector state persists
      end
   end

   function [NPINS*4-1:0] static_codes;
      input [NPINS-1:0] lvl;
      integer k;
      begin
         static_codes = {NPINS*4{1'b0}};
         for (k = 0; k < NPINS; k = k + 1) begin
            static_codes[k*4 +: 4] = lvl[k] ? `VPD_SYM_D1 : `VPD_SYM_D0;
         end
      end
   endfunction

   // checks wait two edges so they line up with the synchronised comparators
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ctx_d1_r    <= {NPINS*4{1'b0}};
         ctx_d2_r    <= {NPINS*4{1'b0}};
         chk2_r      <= 1'b0;
         o_fail      <= 1'b0;
         o_fail_pins <= {NPINS{1'b0}};
         o_cap_valid <= 1'b0;
         o_cap_data  <= {NPINS{1'b0}};
         o_cap_mask  <= {NPINS{1'b0}};
         o_vec_reject <= 1'b0;
         o_term_mode <= `VPD_TERM_HIZ;
      end else begin
         ctx_d1_r     <= ctx_r;
         ctx_d2_r     <= ctx_d1_r;
         chk2_r       <= chk_r[1];
         o_fail       <= |fail_now;
         o_vec_reject <= i_vec_valid & vec_bad;
         o_term_mode  <= cfg_r[`VPD_CFG_TERM_MSB:`VPD_CFG_TERM_LSB];
         o_cap_valid  <= |cap_now;
         o_cap_mask   <= cap_now;
         o_cap_data   <= hi_s2_r & cap_now;
         o_fail_pins  <= fail_keep | fail_now;
      end
   end

   // failure map restarts with each burst; a new failure wins over the restart
   assign fail_keep = (apply & i_vec_first) ? {NPINS{1'b0}} : o_fail_pins;

   assign status_set[`VPD_ST_FAIL]   = |fail_now;
   assign status_set[`VPD_ST_REJECT] = i_vec_valid & vec_bad;
   assign status_set[`VPD_ST_DONE]   = i_burst_end;
   assign status_set[`VPD_ST_CAPT]   = |cap_now;
   assign status_clr = (wr_en && i_paddr == `VPD_REG_IRQ_CLR) ? i_pwdata[`VPD_ST_W-1:0] : {`VPD_ST_W{1'b0}};
   assign o_irq = |(status_r & irq_en_r);

   // apb slave: zero wait states, read data captured in the setup cycle
   always @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         cfg_r       <= `VPD_RST_CFG;
         items_r     <= `VPD_RST_ITEMS;
         grpw_r      <= `VPD_RST_GRPW;
         static_r    <= {NPINS{1'b0}};
         static_ld_r <= 1'b0;
         irq_en_r    <= {`VPD_ST_W{1'b0}};
         status_r    <= {`VPD_ST_W{1'b0}};
         o_prdata    <= 32'h0000_0000;
         o_pslverr   <= 1'b0;
      end else begin
         // set wins over a clear in the same cycle
         status_r    <= (status_r & ~status_clr) | status_set;
         static_ld_r <= wr_en && (i_paddr == `VPD_REG_STATIC);
         if (wr_en) begin
            case (i_paddr)
               `VPD_REG_CFG:    cfg_r    <= i_pwdata[3:0];
               `VPD_REG_ITEMS:  items_r  <= i_pwdata[7:0];
               `VPD_REG_GRPW:   grpw_r   <= i_pwdata[5:0];
               `VPD_REG_STATIC: static_r <= i_pwdata[NPINS-1:0];
               `VPD_REG_IRQ_EN: irq_en_r <= i_pwdata[`VPD_ST_W-1:0];
               default:         cfg_r    <= cfg_r;
            endcase
         end
         if (i_psel & ~i_penable) begin
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            case (i_paddr)
               `VPD_REG_CFG:      if (rd_setup) o_prdata <= {28'h000_0000, cfg_r};
               `VPD_REG_ITEMS:    if (rd_setup) o_prdata <= {24'h00_0000, items_r};
               `VPD_REG_GRPW:     if (rd_setup) o_prdata <= {26'd0, grpw_r};
               `VPD_REG_STATIC:   if (rd_setup) o_prdata <= {{(32-NPINS){1'b0}}, static_r};
               `VPD_REG_STATUS:   if (rd_setup) o_prdata <= {28'h000_0000, status_r};
               `VPD_REG_IRQ_EN:   if (rd_setup) o_prdata <= {28'h000_0000, irq_en_r};
               `VPD_REG_IRQ_CLR:  o_prdata <= 32'h0000_0000;
               `VPD_REG_FAILPINS: if (rd_setup) o_prdata <= {{(32-NPINS){1'b0}}, o_fail_pins};
               // both pin maps share one word, so NPINS may not exceed 16
               `VPD_REG_PINSTATE: if (rd_setup) o_prdata <= {{(32-2*NPINS){1'b0}}, o_drv_val, o_drv_en};
               default:           o_pslverr <= 1'b1;
            endcase
         end
      end
   end

endmodule // vpd_pin_decoder

/* verilog/vpd_sym_decode.v */
`timescale 1ns/1ps
`include "vpd_map.vh"

module vpd_sym_decode (
   input  wire [3:0] i_code,
   input  wire       i_src_bit,
   input  wire       i_src_on,
   output reg        o_drv_en,
   output reg        o_drv_val,
   output reg        o_cmp_en,
   output reg        o_exp_val,
   output reg        o_mid_chk,
   output reg        o_vld_chk,
   output reg        o_src_use
);

   always @* begin
      o_drv_en  = 1'b0;
      o_drv_val = 1'b0;
      o_cmp_en  = 1'b0;
      o_exp_val = 1'b0;
      o_mid_chk = 1'b0;
      o_vld_chk = 1'b0;
      o_src_use = 1'b0;
      case (i_code)
         `VPD_SYM_D0: o_drv_en = 1'b1;
         `VPD_SYM_D1: begin
            o_drv_en  = 1'b1;
            o_drv_val = 1'b1;
         end
         `VPD_SYM_L: o_cmp_en = 1'b1;
         `VPD_SYM_H: begin
            o_cmp_en  = 1'b1;
            o_exp_val = 1'b1;
         end
         `VPD_SYM_M: o_mid_chk = 1'b1;
         `VPD_SYM_V: o_vld_chk = 1'b1;
         // without a configured source these fall back to mask
         `VPD_SYM_SRC_D: begin
            o_drv_en  = i_src_on;
            o_drv_val = i_src_on & i_src_bit;
            o_src_use = i_src_on;
         end
         `VPD_SYM_SRC_E: begin
            o_cmp_en  = i_src_on;
            o_exp_val = i_src_on & i_src_bit;
            o_src_use = i_src_on;
         end
         default: o_drv_en = 1'b0;
      endcase
   end

endmodule // vpd_sym_decode
